// ===== common/sfps_pkg.sv
// Package for the serial flash pin function select block.
// Holds lane indices, pin-role encodings and the packed carriers shared by design and bench.
// Assumes the link logic runs on the serial clock and the core logic on sys_clk_i.
// Overview of operation
// - Restart input low forces idle standby state
// - Pin zero: serial in, or lane zero
// - Pin one: serial out, or lane one
// - Pin two guards writes when quad off, protect-set
// - Quad enabled makes pin two lane two
// - Quad on, select low: pin three lane three
// - Restart enabled, quad off: pin three restarts
// - Restart enabled, quad on: restart only deselected
// - Factory test pad low keeps test inactive
// - Sample rising edge; drive after falling/every edge
// - Deselected ignores lane data, releases every output
// - Restart disabled: pin three never restarts
package sfps_pkg;
   // Transfer width of the command in progress
   typedef enum logic [2:0] {
      SFPS_W_SINGLE = 3'h1,
      SFPS_W_DUAL = 3'h2,
      SFPS_W_QUAD = 3'h4
   } sfps_width_t;

   // Role of the shared pin two
   localparam logic [1:0] SFPS_P2_UNUSED = 2'h0;
   localparam logic [1:0] SFPS_P2_GUARD = 2'h1;
   localparam logic [1:0] SFPS_P2_LANE = 2'h2;
   // Role of the shared pin three
   localparam logic [1:0] SFPS_P3_UNUSED = 2'h0;
   localparam logic [1:0] SFPS_P3_LANE = 2'h1;
   localparam logic [1:0] SFPS_P3_RESTART = 2'h2;
   // Lane positions inside a nibble
   localparam int SFPS_LANE0 = 0;
   localparam int SFPS_LANE1 = 1;
   localparam int SFPS_LANE2 = 2;
   localparam int SFPS_LANE3 = 3;
   // Core-side reset values
   localparam logic SFPS_CFG_RST = 1'h0;
   localparam logic [3:0] SFPS_NIB_RST = 4'h0;

   // Configuration bits steering the pin roles
   typedef struct packed {
      logic quad_enable_bit;
      logic status_write_disable_bit;
      logic pin_restart_enable_bit;
   } sfps_cfg_t;

   // Pad bundle: input, output, output enable per data pin
   typedef struct packed {
      logic [3:0] din;
      logic [3:0] dout;
      logic [3:0] oe;
   } sfps_pads_t;
endpackage : sfps_pkg

// ===== design/sfps_pin_select.sv
// Pin function selector for a multi-purpose serial flash host interface.
// Assumes the host drives spi_clk_i, the pads are resolved outside, and the
// configuration bits come from core logic on sys_clk_i.
`timescale 1ns/1ns
`default_nettype none
module sfps_pin_select
   import sfps_pkg::*;
(
   input wire logic sys_clk_i, // Core clock
   input wire logic rst_b_i, // Core reset, async, active low
   input wire logic spi_clk_i, // Link clock from the host
   input wire logic sel_b_i, // Chip select pin, active low
   input wire logic restart_b_i, // Dedicated restart pin, active low
   input wire logic factory_test_pad_i, // Factory test pad
   input wire sfps_cfg_t cfg_i, // Configuration bits, core domain
   input wire sfps_width_t width_i, // Width of current phase, core domain
   input wire logic ddr_i, // Double rate command, core domain
   input wire logic core_drive_i, // Core wants to send data
   input wire logic [3:0] core_nib_i, // Data to send, low lanes first
   input wire logic [3:0] pad_din_i, // Pad input levels
   output logic [3:0] pad_dout_o, // Pad output levels
   output logic [3:0] pad_oe_o, // Pad enables, high while driven
   output logic [3:0] rx_nib_o, // Sampled inbound lanes, core domain
   output logic write_guard_b_o, // Write guard level, low blocks writes
   output logic standby_rst_o, // Restart request to core, level
   output logic test_active_o // Factory test function enable
);
   // Core-side synchronisers for pins and link data
   logic [1:0] sel_sync_r, sel_sync_nxt;
   logic [1:0] rst_sync_r, rst_sync_nxt;
   logic [1:0] io3_sync_r, io3_sync_nxt;
   logic [1:0] wp_sync_r, wp_sync_nxt;
   logic [1:0] tp_sync_r, tp_sync_nxt;
   logic [3:0] rx_meta_r, rx_meta_nxt;
   logic [3:0] rx_nib_r, rx_nib_nxt;
   // Link-side state
   logic [3:0] samp_r, samp_nxt; // Rising-edge samples
   logic [3:0] out_r, out_nxt; // Launched output data
   logic [3:0] oe_r, oe_nxt; // Launched enables
   logic [3:0] tx_meta_r, tx_nib_r; // Core data into link domain
   logic [3:0] txoe_meta_r, txoe_r; // Core enables into link domain
   logic [3:0] lane_oe; // Lanes the role permits core to drive
   logic [1:0] p2_role, p3_role;

   // Role of pin two from quad and protect bits
   always_comb begin
      if (cfg_i.quad_enable_bit) begin
         p2_role = SFPS_P2_LANE;
      end else if (cfg_i.status_write_disable_bit) begin
         p2_role = SFPS_P2_GUARD;
      end else begin
         p2_role = SFPS_P2_UNUSED;
      end
   end

   // Role of pin three from quad, restart enable and select
   always_comb begin
      if (!cfg_i.pin_restart_enable_bit) begin
         // No restart role at all; lane three only in quad
         p3_role = cfg_i.quad_enable_bit ? SFPS_P3_LANE : SFPS_P3_UNUSED;
      end else if (!cfg_i.quad_enable_bit) begin
         p3_role = SFPS_P3_RESTART;
      end else if (sel_sync_r[1]) begin
         p3_role = SFPS_P3_RESTART;
      end else begin
         p3_role = SFPS_P3_LANE;
      end
   end

   // Lanes the core may drive, by width and pin role
   always_comb begin
      lane_oe = 4'h0;
      unique case (width_i)
         SFPS_W_SINGLE: begin
            lane_oe[SFPS_LANE1] = 1'b1;
         end
         SFPS_W_DUAL: begin
            lane_oe[SFPS_LANE0] = 1'b1;
            lane_oe[SFPS_LANE1] = 1'b1;
         end
         SFPS_W_QUAD: begin
            lane_oe[SFPS_LANE0] = 1'b1;
            lane_oe[SFPS_LANE1] = 1'b1;
            lane_oe[SFPS_LANE2] = (p2_role == SFPS_P2_LANE);
            lane_oe[SFPS_LANE3] = (p3_role == SFPS_P3_LANE);
         end
         default: begin
            lane_oe = 4'h0; // Illegal width drives nothing
         end
      endcase
      if (!core_drive_i) begin
         lane_oe = 4'h0;
      end
   end

   // Core synchroniser next values; first stage is read only by the second
   always_comb begin
      sel_sync_nxt = {sel_sync_r[0], sel_b_i};
      rst_sync_nxt = {rst_sync_r[0], restart_b_i};
      io3_sync_nxt = {io3_sync_r[0], pad_din_i[SFPS_LANE3]};
      wp_sync_nxt = {wp_sync_r[0], pad_din_i[SFPS_LANE2]};
      tp_sync_nxt = {tp_sync_r[0], factory_test_pad_i};
      rx_meta_nxt = samp_r;
      rx_nib_nxt = rx_meta_r;
   end

   // Core synchroniser registers
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sel_sync_r <= 2'h3;
         rst_sync_r <= 2'h3;
         io3_sync_r <= 2'h3;
         wp_sync_r <= 2'h3;
         tp_sync_r <= 2'h0;
         rx_meta_r <= SFPS_NIB_RST;
         rx_nib_r <= SFPS_NIB_RST;
      end else begin
         sel_sync_r <= sel_sync_nxt;
         rst_sync_r <= rst_sync_nxt;
         io3_sync_r <= io3_sync_nxt;
         wp_sync_r <= wp_sync_nxt;
         tp_sync_r <= tp_sync_nxt;
         rx_meta_r <= rx_meta_nxt;
         rx_nib_r <= rx_nib_nxt;
      end
   end

   // Inbound data shown to core; ignored while deselected
   always_comb begin
      rx_nib_o = sel_sync_r[1] ? SFPS_NIB_RST : rx_nib_r;
   end

   // Guard level: only meaningful while the guard role holds.
   // The host must drive it during register writes; a float reads as high.
   always_comb begin
      write_guard_b_o = (p2_role == SFPS_P2_GUARD) ? wp_sync_r[1] : 1'b1;
   end

   // Restart request: dedicated pin, or pin three while it holds the restart role
   always_comb begin
      standby_rst_o = !rst_sync_r[1];
      if (p3_role == SFPS_P3_RESTART && !io3_sync_r[1]) begin
         standby_rst_o = 1'b1;
      end
   end

   // Test function stays inactive while the pad is low
   always_comb begin
      test_active_o = tp_sync_r[1];
   end

   // Rising-edge sampling of all lanes
   always_comb begin
      samp_nxt = pad_din_i;
   end

   always_ff @(posedge spi_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         samp_r <= SFPS_NIB_RST;
      end else begin
         samp_r <= samp_nxt;
      end
   end

   // Core data brought over on the falling edge by two stages.
   // Core holds data steady for a whole link bit, so a word crossing is safe.
   always_ff @(negedge spi_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tx_meta_r <= SFPS_NIB_RST;
         tx_nib_r <= SFPS_NIB_RST;
      end else begin
         tx_meta_r <= core_nib_i;
         tx_nib_r <= tx_meta_r;
      end
   end

   // Output launch: falling edge always, rising edge too in double rate
   always_comb begin
      out_nxt = tx_nib_r;
      oe_nxt = txoe_r;
   end

   always_ff @(negedge spi_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         out_r <= SFPS_NIB_RST;
      end else begin
         out_r <= out_nxt;
      end
   end

   // Enables forget the last frame as soon as select rises. The link clock
   // stops between frames, so without this a new frame would start by
   // driving lanes left over from the previous command, against the host.
   always_ff @(negedge spi_clk_i or negedge rst_b_i or posedge sel_b_i) begin
      if (!rst_b_i || sel_b_i) begin
         txoe_meta_r <= SFPS_NIB_RST;
         txoe_r <= SFPS_NIB_RST;
         oe_r <= SFPS_NIB_RST;
      end else begin
         txoe_meta_r <= lane_oe;
         txoe_r <= txoe_meta_r;
         oe_r <= oe_nxt;
      end
   end

   // Rising-edge copy for double rate launches
   logic [3:0] out_ddr_r, oe_ddr_r;
   always_ff @(posedge spi_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         out_ddr_r <= SFPS_NIB_RST;
      end else begin
         out_ddr_r <= out_nxt;
      end
   end

   // Rising-edge enable copy, cleared with the frame like its partner
   always_ff @(posedge spi_clk_i or negedge rst_b_i or posedge sel_b_i) begin
      if (!rst_b_i || sel_b_i) begin
         oe_ddr_r <= SFPS_NIB_RST;
      end else begin
         oe_ddr_r <= oe_nxt;
      end
   end

   // Pad drive; select high or restart releases every output.
   // Select is read raw here so release is immediate, not two clocks late.
   always_comb begin
      pad_dout_o = (ddr_i && spi_clk_i) ? out_ddr_r : out_r;
      pad_oe_o = (ddr_i && spi_clk_i) ? oe_ddr_r : oe_r;
      if (sel_b_i || standby_rst_o) begin
         pad_oe_o = 4'h0;
      end
   end
endmodule : sfps_pin_select
`default_nettype wire

// ===== dv/sfps_pin_select_assertions.sv
// Checker for the pin function selector, watching its ports only.
// Assumes one core clock; pins need two edges to pass the syncs.
`timescale 1ns/1ns
`default_nettype none
module sfps_pin_select_assertions
   import sfps_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic sel_b_i,
   input wire logic restart_b_i,
   input wire logic factory_test_pad_i,
   input wire sfps_cfg_t cfg_i,
   input wire logic [3:0] pad_din_i,
   input wire logic [3:0] pad_oe_o,
   input wire logic [3:0] rx_nib_o,
   input wire logic write_guard_b_o,
   input wire logic standby_rst_o,
   input wire logic test_active_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   // Pin three held low under one setting; four cycles cover the sync lag
   sequence s_p3(c, sl);
      (cfg_i == c && sel_b_i == sl && !pad_din_i[3] && restart_b_i)[*4];
   endsequence
   a_restart_pin: assert property ($fell(restart_b_i) |-> ##[1:3] standby_rst_o) else $error("restart lost");
   a_desel_idle: assert property (sel_b_i |-> pad_oe_o == 4'h0) else $error("pad driven");
   a_desel_rx: assert property (sel_b_i [*4] |-> rx_nib_o == 4'h0) else $error("rx not zero");
   a_guard_low: assert property ((cfg_i == 3'b010 && !pad_din_i[2])[*4] |-> !write_guard_b_o)
      else $error("guard open");
   a_guard_quad: assert property (cfg_i.quad_enable_bit [*4] |-> write_guard_b_o) else $error("guard in quad");
   a_test_pad: assert property ((!factory_test_pad_i)[*3] |-> !test_active_o) else $error("test on");
   a_p3_none: assert property (s_p3(3'b000, 1'b1) |-> !standby_rst_o) else $error("pin restart off");
   a_p3_restart: assert property (s_p3(3'b001, 1'b1) |-> standby_rst_o) else $error("pin restart");
   a_p3_quad_idle: assert property (s_p3(3'b101, 1'b1) |-> standby_rst_o) else $error("quad restart");
   a_p3_quad_lane: assert property (s_p3(3'b101, 1'b0) |-> !standby_rst_o) else $error("lane restart");
endmodule : sfps_pin_select_assertions
bind sfps_pin_select sfps_pin_select_assertions sfps_pin_select_assertions_inst (.sys_clk_i, .rst_b_i, .sel_b_i,
   .restart_b_i, .factory_test_pad_i, .cfg_i, .pad_din_i, .pad_oe_o, .rx_nib_o, .write_guard_b_o, .standby_rst_o,
   .test_active_o);
`default_nettype wire

// ===== dv/sfps_host_model.sv
// Host controller model: select, link clock and lane levels.
// Assumes the bench calls its tasks away from the core clock edge.
`timescale 1ns/1ns
`default_nettype none
module sfps_host_model (
   input wire logic [3:0] dev_dout_i,
   input wire logic [3:0] dev_oe_i,
   output logic spi_clk_o,
   output logic sel_b_o,
   output logic [3:0] pad_o
);
   logic [3:0] drv = 4'h0; // Host levels
   logic [3:0] en = 4'h0; // Host enables
   logic [3:0] last = 4'h0; // Last host levels
   initial spi_clk_o = 1'b0;
   initial sel_b_o = 1'b1;
   // Pins two and three pull up; floating pins zero and one flip, so no stale value survives
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pad_o[i] = dev_oe_i[i] ? dev_dout_i[i] : en[i] ? drv[i] : (i > 1) ? 1'b1 : ~last[i];
      end
   end
   // Changes land while the link clock is low
   task automatic drive(input logic sel_b, input logic [3:0] d, input logic [3:0] e);
      last = drv;
      sel_b_o = sel_b;
      drv = d;
      en = e;
   endtask : drive
   // Clock only inside frames
   task automatic run(input int n);
      repeat (n) begin
         #6 spi_clk_o = 1'b1;
         #6 spi_clk_o = 1'b0;
      end
   endtask : run
endmodule : sfps_host_model
`default_nettype wire

// ===== dv/tb.sv
// Bench for the pin function selector with a host model on the pads.
// Assumes the core clock at 100 MHz and a stoppable 12 ns link clock.
`timescale 1ns/1ns
`default_nettype none
module tb
   import sfps_pkg::*;
;
   logic sys_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic restart_b = 1'b1;
   logic tpad = 1'b0;
   logic drv = 1'b0;
   logic [3:0] nib = 4'h5;
   sfps_cfg_t cfg = '0;
   sfps_width_t wd = SFPS_W_QUAD;
   wire logic sclk, sel_b, gd, sb, ta;
   wire logic [3:0] pads, dout, oe, rx;
   int num_errors = 0;
   int checks = 0;
   always #5 sys_clk_i = ~sys_clk_i;
   sfps_pin_select sfps_pin_select_inst (.sys_clk_i, .rst_b_i, .spi_clk_i(sclk), .sel_b_i(sel_b),
      .restart_b_i(restart_b), .factory_test_pad_i(tpad), .cfg_i(cfg), .width_i(wd), .ddr_i(1'b0),
      .core_drive_i(drv), .core_nib_i(nib), .pad_din_i(pads), .pad_dout_o(dout), .pad_oe_o(oe), .rx_nib_o(rx),
      .write_guard_b_o(gd), .standby_rst_o(sb), .test_active_o(ta));
   sfps_host_model sfps_host_model_inst (.dev_dout_i(dout), .dev_oe_i(oe), .spi_clk_o(sclk), .sel_b_o(sel_b),
      .pad_o(pads));
   task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask : chk
   // Wait out the two-flop syncs
   task automatic settle();
      repeat (4) @(negedge sys_clk_i);
   endtask : settle
   task automatic hs(input logic s, input logic [3:0] d, input logic [3:0] e);
      sfps_host_model_inst.drive(s, d, e);
   endtask : hs
   // Each width enables its own lanes, then deselect releases them
   task automatic t_widths();
      sfps_width_t w[3] = '{SFPS_W_SINGLE, SFPS_W_DUAL, SFPS_W_QUAD};
      logic [3:0] e[3] = '{4'h2, 4'h3, 4'hF};
      cfg = 3'b100;
      drv = 1'b1;
      for (int i = 0; i < 3; i++) begin
         wd = w[i];
         hs(1'b0, 4'h0, 4'h0);
         sfps_host_model_inst.run(4);
         settle();
         chk("lane oe", e[i], oe);
         chk("lane data", e[i] & 4'h5, dout & e[i]);
         hs(1'b1, 4'h0, 4'h0);
         #1 chk("oe off", 4'h0, oe);
      end
      drv = 1'b0;
      hs(1'b0, 4'h6, 4'hF);
      sfps_host_model_inst.run(4);
      settle();
      chk("rx quad", 4'h6, rx);
      hs(1'b1, 4'h0, 4'h0);
      settle();
      chk("rx idle", 4'h0, rx);
   endtask : t_widths
   // Guard role by configuration and pin two level
   task automatic t_guard();
      logic [2:0] c[3] = '{3'b010, 3'b010, 3'b110};
      logic [3:0] p[3] = '{4'h0, 4'h4, 4'h0};
      for (int i = 0; i < 3; i++) begin
         cfg = c[i];
         hs(1'b0, p[i], 4'h4);
         settle();
         chk("guard", {3'h0, p[i][2] | c[i][2]}, {3'h0, gd});
      end
      hs(1'b1, 4'h0, 4'h0);
   endtask : t_guard
   // Pin three held low: {enable, quad, select, expected}; then the dedicated pin and test pad
   task automatic t_restart();
      logic [3:0] t[5] = '{4'b0010, 4'b0110, 4'b1011, 4'b1111, 4'b1100};
      for (int i = 0; i < 5; i++) begin
         cfg = {t[i][2], 1'b0, t[i][3]};
         hs(t[i][1], 4'h0, 4'h8);
         settle();
         chk("pin3 restart", {3'h0, t[i][0]}, {3'h0, sb});
         hs(1'b1, 4'h0, 4'h0);
         settle();
      end
      restart_b = 1'b0;
      tpad = 1'b1;
      settle();
      chk("restart", 4'h3, {2'h0, sb, ta});
      restart_b = 1'b1;
      tpad = 1'b0;
      settle();
      chk("idle", 4'h0, {2'h0, sb, ta});
   endtask : t_restart
   task automatic end_sim();
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_sim
   initial begin
      // First drive at a falling edge, clear of the model's own start-up
      @(negedge sys_clk_i);
      hs(1'b0, 4'h0, 4'h0);
      sfps_host_model_inst.run(2);
      hs(1'b1, 4'h0, 4'h0);
      repeat (12) @(negedge sys_clk_i);
      rst_b_i = 1'b1;
      settle();
      t_widths();
      t_guard();
      t_restart();
      end_sim();
   end
   // Watchdog well past the microsecond or so the tests need
   initial begin
      #100000;
      num_errors++;
      end_sim();
   end
endmodule : tb
`default_nettype wire
